// ---- design/sfc_cfg.svh ----
// Constants for the switch port flow-control register bank.
// Assumes inclusion by bare name from design files.
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH
`define SFC_OFF_P2 12'h1A4
`define SFC_OFF_P0 12'h1A8
`define SFC_BIT_BP 6
`define SFC_BIT_DUP 5
`define SFC_BIT_CRX 4
`define SFC_BIT_CTX 3
`define SFC_BIT_RX 2
`define SFC_BIT_TX 1
`define SFC_BIT_MAN 0
`define SFC_RESP_OKAY 2'h0
`define SFC_RESP_SLVERR 2'h2
`define SFC_NPORT 2
`endif

// ---- design/sfc_pkg.sv ----
// Types for the switch port flow-control register bank.
// Assumes nothing of its surroundings.
package sfc_pkg;
    typedef enum logic [1:0] {
        SFC_W_IDLE,
        SFC_W_RESP
    } sfc_wstate_t;
    typedef enum logic [0:0] {
        SFC_R_IDLE,
        SFC_R_RESP
    } sfc_rstate_t;
endpackage

// ---- design/sfc_port_fc.sv ----
// One port's flow-control settings and the resolved pause/backpressure state.
// Assumes strap, duplex and negotiation inputs synchronous to aclk.
`timescale 1ns/10ps
`include "sfc_cfg.svh"
module sfc_port_fc (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic mac_mode,
    input wire logic bp_strap,
    input wire logic pause_strap,
    input wire logic man_strap,
    input wire logic strap_reload,
    input wire logic wr_en,
    input wire logic [6:0] wr_data,
    input wire logic half_duplex,
    input wire logic an_enable,
    input wire logic an_rx_pause,
    input wire logic an_tx_pause,
    output logic [6:0] rd_word,
    output logic bp_active,
    output logic rx_pause_active,
    output logic tx_pause_active
);
    logic bp_en_r;
    logic rx_en_r;
    logic tx_en_r;
    logic man_r;
    logic load_r;
    logic use_manual;
    logic rx_nxt;
    logic tx_nxt;

    // Straps sampled on the first clock after release, and on each reload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_r <= 1'b1;
        end else begin
            load_r <= 1'b0;
        end
    end

    // Writable fields; software writes never touch the advertisement
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bp_en_r <= 1'b0;
            rx_en_r <= 1'b0;
            tx_en_r <= 1'b0;
            man_r <= 1'b0;
        end else if (load_r || strap_reload) begin // R10
            bp_en_r <= bp_strap;
            rx_en_r <= pause_strap;
            tx_en_r <= pause_strap;
            man_r <= mac_mode ? 1'b1 : man_strap; // R14
        end else if (wr_en) begin // R11 R13
            bp_en_r <= wr_data[`SFC_BIT_BP]; // R1
            rx_en_r <= wr_data[`SFC_BIT_RX]; // R6
            tx_en_r <= wr_data[`SFC_BIT_TX]; // R7
            man_r <= mac_mode ? 1'b1 : wr_data[`SFC_BIT_MAN]; // R14
        end else if (mac_mode) begin
            man_r <= 1'b1; // R14
        end
    end

    // Manual enables used when selected or negotiation is off
    assign use_manual = man_r || mac_mode || !an_enable; // R8 R9 R12
    assign rx_nxt = !half_duplex && (use_manual ? rx_en_r : an_rx_pause); // R16
    assign tx_nxt = !half_duplex && (use_manual ? tx_en_r : an_tx_pause); // R16

    // Effective state registered so outputs come from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_pause_active <= 1'b0;
            tx_pause_active <= 1'b0;
            bp_active <= 1'b0;
        end else begin
            rx_pause_active <= rx_nxt; // R5
            tx_pause_active <= tx_nxt; // R5
            bp_active <= half_duplex && bp_en_r; // R1 R16
        end
    end

    // Read image: duplex live, current pause from the flops above
    assign rd_word = {bp_en_r, half_duplex, rx_pause_active, tx_pause_active,
                      rx_en_r, tx_en_r, man_r || mac_mode}; // R2 R3 R4

    a_rx_effect: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        rx_pause_active |-> !$past(half_duplex))
        else $error("rx pause active in half duplex");
    a_tx_effect: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        tx_pause_active |-> !$past(half_duplex))
        else $error("tx pause active in half duplex");
    a_man_forced: assert property (@(posedge aclk) disable iff (!aresetn) // R14
        mac_mode && $past(mac_mode) |-> man_r)
        else $error("manual select not forced in mac mode");
endmodule

// ---- design/sfc_regs.sv ----
// Behaviour
// R1 - bit 6 enables half-duplex backpressure
// R2 - bit 5 reads duplex, 1 is half
// R3 - bit 4 reads receive pause in effect
// R4 - bit 3 reads transmit pause in effect
// R5 - current bits follow effective settings
// R6 - bit 2 manual receive pause enable
// R7 - bit 1 manual transmit pause enable
// R8 - select clear: negotiation if enabled, else manual
// R9 - select set: manual enables govern full duplex
// R10 - defaults from straps, reloaded by loader
// R11 - writes leave transceiver advertisement alone
// R12 - host port receive enable follows manual rules
// R13 - host port writes leave emulated advertisement
// R14 - MAC mode forces select high, read-only
// R15 - bits 31 to 7 read zero
// R16 - pause in full, backpressure in half
//
// AXI4-Lite register bank for switch port 2 and port 0 flow control.
// Assumes AXI4-Lite master on aclk; status inputs synchronous to aclk.
`timescale 1ns/10ps
`include "sfc_cfg.svh"
module sfc_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic p0_mac_mode,
    input wire logic [1:0] backpressure_strap,
    input wire logic [1:0] pause_enable_strap,
    input wire logic [1:0] manual_select_strap,
    input wire logic strap_reload,
    input wire logic [1:0] port_half_duplex,
    input wire logic [1:0] port_an_enable,
    input wire logic [1:0] port_an_rx_pause,
    input wire logic [1:0] port_an_tx_pause,
    output logic [1:0] port_backpressure_active,
    output logic [1:0] port_rx_pause_active,
    output logic [1:0] port_tx_pause_active
);
    // Index 0 is port 2, index 1 is port 0 (the host-facing port)
    sfc_pkg::sfc_wstate_t wstate_r;
    sfc_pkg::sfc_rstate_t rstate_r;
    logic aw_have_r;
    logic w_have_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] wr_en;
    logic [6:0] rd_word [`SFC_NPORT];
    logic [1:0] bp_w;
    logic [1:0] rx_w;
    logic [1:0] tx_w;
    logic [1:0] mac_w;

    // Decode a byte address to a port index; bit 1 flags a hit
    function automatic logic [1:0] sfc_decode(input logic [11:0] addr);
        if (addr == `SFC_OFF_P2) begin
            sfc_decode = 2'h2;
        end else if (addr == `SFC_OFF_P0) begin
            sfc_decode = 2'h3;
        end else begin
            sfc_decode = 2'h0;
        end
    endfunction

    assign mac_w = {p0_mac_mode, 1'b0};

    // One instance per port
    genvar gi;
    generate
        for (gi = 0; gi < `SFC_NPORT; gi++) begin : g_port
            sfc_port_fc u_port (
                .aclk(aclk),
                .aresetn(aresetn),
                .mac_mode(mac_w[gi]),
                .bp_strap(backpressure_strap[gi]),
                .pause_strap(pause_enable_strap[gi]),
                .man_strap(manual_select_strap[gi]),
                .strap_reload(strap_reload),
                .wr_en(wr_en[gi]),
                .wr_data(wdata_r[6:0]),
                .half_duplex(port_half_duplex[gi]),
                .an_enable(port_an_enable[gi]),
                .an_rx_pause(port_an_rx_pause[gi]),
                .an_tx_pause(port_an_tx_pause[gi]),
                .rd_word(rd_word[gi]),
                .bp_active(bp_w[gi]),
                .rx_pause_active(rx_w[gi]),
                .tx_pause_active(tx_w[gi])
            );
        end
    endgenerate

    // Effective flow state already registered inside each port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_backpressure_active <= 2'h0;
            port_rx_pause_active <= 2'h0;
            port_tx_pause_active <= 2'h0;
        end else begin
            port_backpressure_active <= bp_w;
            port_rx_pause_active <= rx_w;
            port_tx_pause_active <= tx_w;
        end
    end

    // Write: take address and data in either order, then respond
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate_r <= sfc_pkg::SFC_W_IDLE;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SFC_RESP_OKAY;
        end else begin
            case (wstate_r)
                sfc_pkg::SFC_W_IDLE: begin
                    s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
                    s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_have_r <= 1'b1;
                        awaddr_r <= s_axi_awaddr;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_have_r <= 1'b1;
                        wdata_r <= s_axi_wdata;
                        wstrb_r <= s_axi_wstrb;
                    end
                    if (aw_have_r && w_have_r) begin
                        aw_have_r <= 1'b0;
                        w_have_r <= 1'b0;
                        s_axi_awready <= 1'b0;
                        s_axi_wready <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        // A function result cannot be bit-selected, so compare it whole
                        s_axi_bresp <= (sfc_decode(awaddr_r) != 2'h0) ? `SFC_RESP_OKAY
                                                                      : `SFC_RESP_SLVERR;
                        wstate_r <= sfc_pkg::SFC_W_RESP;
                    end
                end
                sfc_pkg::SFC_W_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wstate_r <= sfc_pkg::SFC_W_IDLE;
                    end
                end
                default: wstate_r <= sfc_pkg::SFC_W_IDLE;
            endcase
        end
    end

    // Commit on the cycle the response is raised; only low byte lane matters
    always_comb begin
        wr_en = 2'h0;
        if (wstate_r == sfc_pkg::SFC_W_IDLE && aw_have_r && w_have_r && wstrb_r[0]) begin
            if (sfc_decode(awaddr_r) == 2'h2) begin
                wr_en[0] = 1'b1;
            end else if (sfc_decode(awaddr_r) == 2'h3) begin
                wr_en[1] = 1'b1;
            end
        end
    end

    // Read: one cycle after address accept, upper bits zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rstate_r <= sfc_pkg::SFC_R_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SFC_RESP_OKAY;
        end else begin
            case (rstate_r)
                sfc_pkg::SFC_R_IDLE: begin
                    s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
                    if (s_axi_arvalid && s_axi_arready) begin
                        s_axi_rvalid <= 1'b1;
                        rstate_r <= sfc_pkg::SFC_R_RESP;
                        if (sfc_decode(s_axi_araddr) == 2'h2) begin
                            s_axi_rdata <= {25'h0000000, rd_word[0]}; // R15
                            s_axi_rresp <= `SFC_RESP_OKAY;
                        end else if (sfc_decode(s_axi_araddr) == 2'h3) begin
                            s_axi_rdata <= {25'h0000000, rd_word[1]}; // R15
                            s_axi_rresp <= `SFC_RESP_OKAY;
                        end else begin
                            s_axi_rdata <= 32'h0000_0000;
                            s_axi_rresp <= `SFC_RESP_SLVERR;
                        end
                    end
                end
                sfc_pkg::SFC_R_RESP: begin
                    s_axi_arready <= 1'b0;
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                        rstate_r <= sfc_pkg::SFC_R_IDLE;
                    end
                end
                default: rstate_r <= sfc_pkg::SFC_R_IDLE;
            endcase
        end
    end

    // Read image: reserved bits zero, live status fields per port
    a_rsvd_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R15
        s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0000000)
        else $error("reserved read bits not zero");
    a_duplex_read: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `SFC_OFF_P2
        |=> s_axi_rdata[`SFC_BIT_DUP] == $past(port_half_duplex[0]))
        else $error("duplex read mismatch");
    a_duplex_host: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `SFC_OFF_P0
        |=> s_axi_rdata[`SFC_BIT_DUP] == $past(port_half_duplex[1]))
        else $error("host duplex read mismatch");
    a_rx_read: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `SFC_OFF_P0
        |=> s_axi_rdata[`SFC_BIT_CRX] == $past(rx_w[1]))
        else $error("rx pause read mismatch");
    a_rx_port2: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `SFC_OFF_P2
        |=> s_axi_rdata[`SFC_BIT_CRX] == $past(rx_w[0]))
        else $error("port2 rx pause read mismatch");
    a_tx_read: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `SFC_OFF_P2
        |=> s_axi_rdata[`SFC_BIT_CTX] == $past(tx_w[0]))
        else $error("tx pause read mismatch");
    a_tx_host: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `SFC_OFF_P0
        |=> s_axi_rdata[`SFC_BIT_CTX] == $past(tx_w[1]))
        else $error("host tx pause read mismatch");

    // Backpressure only in half duplex; the outputs lag the input by two flops
    a_bp_half: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        port_backpressure_active[0] |-> $past(port_half_duplex[0], 2))
        else $error("backpressure outside half duplex");
    a_bp_host: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        port_backpressure_active[1] |-> $past(port_half_duplex[1], 2))
        else $error("host backpressure outside half duplex");

    // Effective pause source: manual enables versus negotiated results
    a_manual_rx: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        !port_half_duplex[0] && !port_an_enable[0] && !wr_en[0] && !strap_reload
        && $stable(port_half_duplex[0]) && $stable(port_an_enable[0])
        |=> ##1 port_rx_pause_active[0] == $past(rd_word[0][`SFC_BIT_RX], 2))
        else $error("manual rx pause not applied");
    a_manual_tx: assert property (@(posedge aclk) disable iff (!aresetn) // R7
        !port_half_duplex[0] && !port_an_enable[0]
        |=> ##1 port_tx_pause_active[0] == $past(rd_word[0][`SFC_BIT_TX], 2))
        else $error("manual tx pause not applied");
    a_neg_rx: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        !port_half_duplex[0] && port_an_enable[0] && !rd_word[0][`SFC_BIT_MAN]
        |=> ##1 port_rx_pause_active[0] == $past(port_an_rx_pause[0], 2))
        else $error("negotiated rx pause not applied");
    a_manual_host: assert property (@(posedge aclk) disable iff (!aresetn) // R12
        !port_half_duplex[1] && rd_word[1][`SFC_BIT_MAN]
        |=> ##1 port_rx_pause_active[1] == $past(rd_word[1][`SFC_BIT_RX], 2))
        else $error("host manual rx pause not applied");

    // Writable fields land one cycle after the commit; host select reads high in MAC mode
    a_bp_write: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        wr_en[1] && !strap_reload
        |=> rd_word[1][`SFC_BIT_BP] == $past(wdata_r[`SFC_BIT_BP]))
        else $error("backpressure enable write lost");
    a_mac_select: assert property (@(posedge aclk) disable iff (!aresetn) // R14
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `SFC_OFF_P0 && p0_mac_mode
        |=> s_axi_rdata[`SFC_BIT_MAN])
        else $error("host select not high in mac mode");

    // Bus side: refusals, okay write answers and channel closing while a response stands
    a_unmapped_rd: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && sfc_decode(s_axi_araddr) == 2'h0
        |=> s_axi_rresp == `SFC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_unmapped_wr: assert property (@(posedge aclk) disable iff (!aresetn)
        wstate_r == sfc_pkg::SFC_W_IDLE && aw_have_r && w_have_r
        && sfc_decode(awaddr_r) == 2'h0
        |=> s_axi_bvalid && s_axi_bresp == `SFC_RESP_SLVERR)
        else $error("unmapped write not refused");
    a_mapped_wr: assert property (@(posedge aclk) disable iff (!aresetn)
        wstate_r == sfc_pkg::SFC_W_IDLE && aw_have_r && w_have_r
        && sfc_decode(awaddr_r) != 2'h0
        |=> s_axi_bvalid && s_axi_bresp == `SFC_RESP_OKAY)
        else $error("mapped write not answered okay");
    a_aw_closed: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels open during response");
    a_ar_closed: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open during response");
endmodule

// ---- tb/sfc_regs_tb.sv ----
// Self-checking bench for the port flow-control register bank.
// Assumes design/ on the include path; the bench is the only bus master.
`timescale 1ns/10ps
`include "sfc_cfg.svh"
module testbench;
    logic aclk;
    logic aresetn;
    logic [11:0] awaddr;
    logic [11:0] araddr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic mac_mode, reload;
    logic [1:0] bp_st, pe_st, ms_st, hd, ane, anrx, antx;
    logic [1:0] bp_act, rx_act, tx_act;
    int n_fail;
    int n_compared;

    sfc_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .p0_mac_mode(mac_mode),
        .backpressure_strap(bp_st), .pause_enable_strap(pe_st), .manual_select_strap(ms_st),
        .strap_reload(reload), .port_half_duplex(hd), .port_an_enable(ane),
        .port_an_rx_pause(anrx), .port_an_tx_pause(antx), .port_backpressure_active(bp_act),
        .port_rx_pause_active(rx_act), .port_tx_pause_active(tx_act));

    // Free-running system clock, 8 ns period
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Reads see pre-edge values, since the design updates by non-blocking assignment
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic aw_done;
        logic w_done;
        int t;
        aw_done = 1'b0;
        w_done = 1'b0;
        t = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done) && t < 100) begin
            @(posedge aclk);
            t++;
            if (awvalid && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid && t < 100) begin
            @(posedge aclk);
            t++;
        end
        bready <= 1'b0;
        if (t >= 100) n_fail++;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        int t;
        t = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
        end while (!(arvalid && arready) && t < 100);
        arvalid <= 1'b0;
        while (!rvalid && t < 100) begin
            @(posedge aclk);
            t++;
        end
        rready <= 1'b0;
        if (t >= 100) n_fail++;
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    // Status inputs reach the outputs two cycles late; four gives margin
    task automatic settle();
        repeat (4) @(posedge aclk);
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        finish_test();
    end

    initial begin
        n_fail = 0;
        n_compared = 0;
        aresetn = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready, mac_mode, reload} = '0;
        bp_st = 2'h1;
        pe_st = 2'h1;
        ms_st = 2'h2;
        hd = 2'h0;
        ane = 2'h1;
        anrx = 2'h1;
        antx = 2'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        axi_read(`SFC_OFF_P2, 32'h56, `SFC_RESP_OKAY);
        axi_read(`SFC_OFF_P0, 32'h01, `SFC_RESP_OKAY);
        chk({30'h0, rx_act}, 32'h1);
        axi_write(`SFC_OFF_P2, 32'hFFFFFFFF, 4'hF, `SFC_RESP_OKAY);
        settle();
        axi_read(`SFC_OFF_P2, 32'h5F, `SFC_RESP_OKAY);
        chk({30'h0, tx_act}, 32'h1);
        hd <= 2'h1;
        settle();
        axi_read(`SFC_OFF_P2, 32'h67, `SFC_RESP_OKAY);
        chk({26'h0, bp_act, rx_act, tx_act}, 32'h10);
        axi_write(`SFC_OFF_P2, 32'h0, 4'hF, `SFC_RESP_OKAY);
        settle();
        axi_read(`SFC_OFF_P2, 32'h20, `SFC_RESP_OKAY);
        chk({30'h0, bp_act}, 32'h0);
        hd <= 2'h0;
        ane <= 2'h0;
        axi_write(`SFC_OFF_P2, 32'h04, 4'hF, `SFC_RESP_OKAY);
        settle();
        axi_read(`SFC_OFF_P2, 32'h14, `SFC_RESP_OKAY);
        axi_write(`SFC_OFF_P2, 32'h02, 4'hF, `SFC_RESP_OKAY);
        settle();
        axi_read(`SFC_OFF_P2, 32'h0A, `SFC_RESP_OKAY);
        ane <= 2'h1;
        antx <= 2'h1;
        settle();
        axi_read(`SFC_OFF_P2, 32'h1A, `SFC_RESP_OKAY);
        axi_write(`SFC_OFF_P2, 32'h41, 4'h0, `SFC_RESP_OKAY);
        axi_write(12'h1AC, 32'h41, 4'hF, `SFC_RESP_SLVERR);
        axi_read(12'h1AC, 32'h0, `SFC_RESP_SLVERR);
        axi_read(`SFC_OFF_P2, 32'h1A, `SFC_RESP_OKAY);
        mac_mode <= 1'b1;
        ane <= 2'h3;
        anrx <= 2'h3;
        antx <= 2'h3;
        axi_write(`SFC_OFF_P0, 32'h0, 4'hF, `SFC_RESP_OKAY);
        settle();
        axi_read(`SFC_OFF_P0, 32'h01, `SFC_RESP_OKAY);
        axi_write(`SFC_OFF_P0, 32'h06, 4'hF, `SFC_RESP_OKAY);
        settle();
        axi_read(`SFC_OFF_P0, 32'h1F, `SFC_RESP_OKAY);
        chk({30'h0, rx_act}, 32'h3);
        // Loader rewrites straps; one-cycle pulse
        bp_st <= 2'h2;
        pe_st <= 2'h2;
        ms_st <= 2'h1;
        reload <= 1'b1;
        @(posedge aclk);
        reload <= 1'b0;
        settle();
        axi_read(`SFC_OFF_P2, 32'h01, `SFC_RESP_OKAY);
        axi_read(`SFC_OFF_P0, 32'h5F, `SFC_RESP_OKAY);
        // Host port in half duplex: backpressure on, pause off
        hd <= 2'h2;
        settle();
        axi_read(`SFC_OFF_P0, 32'h67, `SFC_RESP_OKAY);
        chk({26'h0, bp_act, rx_act, tx_act}, 32'h20);
        // Leaving MAC mode makes the host select writable again
        mac_mode <= 1'b0;
        hd <= 2'h0;
        axi_write(`SFC_OFF_P0, 32'h0, 4'hF, `SFC_RESP_OKAY);
        settle();
        axi_read(`SFC_OFF_P0, 32'h18, `SFC_RESP_OKAY);
        chk({30'h0, tx_act}, 32'h2);
        finish_test();
    end
endmodule
